// *** logic/dmr_cfg.svh ***
// Constants for the strobe oscillator, calibration invert and termination mode registers
`ifndef DMR_CFG_SVH
`define DMR_CFG_SVH
`define DMR_ADDR_OSC_LOW 6'h12
`define DMR_ADDR_OSC_HIGH 6'h13
`define DMR_ADDR_INV_MASK 6'h14
`define DMR_ADDR_RSVD_21 6'h15
`define DMR_ADDR_TERM_CTRL 6'h16
`define DMR_TERM_CODE_MSB 2
`define DMR_TERM_CK_BIT 3
`define DMR_TERM_CS_BIT 4
`define DMR_TERM_CA_BIT 5
`define DMR_TERM_USED_W 6
`define DMR_TERM_RESET 6'h00
`define DMR_TERM_CODE_OFF 3'h0
`define DMR_TERM_CODE_RSVD 3'h7
`define DMR_MASK_RESET 8'h00
`define DMR_SYNC_STAGES 3
`endif

// *** logic/dmr_mode_regs.sv ***
// Mode register slice: oscillator count, upper invert mask, termination overrides
`timescale 1ns/100ps
`include "dmr_cfg.svh"
module dmr_mode_regs #(
  parameter int COUNT_W = 16
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Mode register commands
  input wire logic mrw_valid_in,
  input wire logic mrr_valid_in,
  input wire dmr_pkg::dmr_addr_t mr_addr_in,
  input wire dmr_pkg::dmr_byte_t mr_wdata_in,
  output dmr_pkg::dmr_byte_t mrr_data_out,
  output logic mrr_valid_out,
  // Oscillator commands
  input wire logic osc_start_in,
  input wire logic osc_stop_in,
  input wire logic osc_tick_in,
  output logic osc_running_out,
  // Set point and io configuration
  input wire logic write_set_point_select_in,
  input wire logic active_set_point_select_in,
  input wire logic bus_inversion_enable_in,
  input wire logic term_value_valid_in,
  // Bond pad
  input wire logic cmd_bus_term_pad_in,
  // Read calibration path
  input wire logic cal_active_in,
  input wire dmr_pkg::dmr_byte_t cal_pattern_in,
  input wire logic cal_mask_pattern_in,
  output dmr_pkg::dmr_byte_t cal_upper_dq_out,
  output logic mask_inversion_pin_out,
  output logic bus_inversion_apply_out,
  // Termination controls
  output logic [2:0] controller_term_strength_out,
  output logic controller_term_rsvd_out,
  output logic clock_term_en_out,
  output logic chip_select_term_en_out,
  output logic cmd_addr_term_en_out
);
  import dmr_pkg::*;

  // Register state
  logic [COUNT_W-1:0] osc_count;  // Oscillator count
  dmr_byte_t upper_byte_cal_invert_mask;  // Calibration invert mask
  logic [`DMR_TERM_USED_W-1:0] term_copy [2];  // Termination copies per set point
  logic [`DMR_SYNC_STAGES-1:0] pad_sync;  // Bond pad synchroniser
  logic pad_level;  // Filtered pad level

  // Oscillator counter
  dmr_osc_counter #(
    .COUNT_W(COUNT_W)
  ) u_osc (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .start_in(osc_start_in),
    .stop_in(osc_stop_in),
    .tick_in(osc_tick_in),
    .count_out(osc_count),
    .running_out(osc_running_out)
  );

  // Address decode
  wire hit_mask = mr_addr_in == `DMR_ADDR_INV_MASK;
  wire hit_term = mr_addr_in == `DMR_ADDR_TERM_CTRL;
  wire wr_mask = mrw_valid_in && hit_mask;
  wire wr_term = mrw_valid_in && hit_term;
  wire [`DMR_TERM_USED_W-1:0] wr_term_copy = term_copy[write_set_point_select_in];
  wire [`DMR_TERM_USED_W-1:0] act_term = term_copy[active_set_point_select_in];

  // Read data select, reserved slot and unmapped addresses read zero
  dmr_byte_t rd_data;
  always_comb begin
    unique case (mr_addr_in)
      `DMR_ADDR_OSC_LOW: rd_data = osc_count[7:0];
      `DMR_ADDR_OSC_HIGH: rd_data = osc_count[15:8];
      `DMR_ADDR_INV_MASK: rd_data = upper_byte_cal_invert_mask;
      `DMR_ADDR_TERM_CTRL: rd_data = {2'b00, wr_term_copy};
      default: rd_data = 8'h00;
    endcase
  end

  // Mode register read response
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      mrr_data_out <= 8'h00;
      mrr_valid_out <= 1'b0;
    end else begin
      mrr_valid_out <= mrr_valid_in;
      if (mrr_valid_in) mrr_data_out <= rd_data;
    end
  end

  // Writable registers; writes to read-only and reserved slots are dropped
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      upper_byte_cal_invert_mask <= `DMR_MASK_RESET;
      term_copy[0] <= `DMR_TERM_RESET;
      term_copy[1] <= `DMR_TERM_RESET;
    end else begin
      if (wr_mask) upper_byte_cal_invert_mask <= mr_wdata_in;
      if (wr_term) term_copy[write_set_point_select_in] <= mr_wdata_in[`DMR_TERM_USED_W-1:0];
    end
  end

  // Bond pad synchroniser, level taken when last two stages agree
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pad_sync <= '0;
      pad_level <= 1'b0;
    end else begin
      pad_sync <= {pad_sync[`DMR_SYNC_STAGES-2:0], cmd_bus_term_pad_in};
      if (pad_sync[2] == pad_sync[1]) pad_level <= pad_sync[2];
    end
  end

  // Calibration output path
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cal_upper_dq_out <= 8'h00;
      mask_inversion_pin_out <= 1'b0;
    end else begin
      cal_upper_dq_out <= cal_pattern_in ^ upper_byte_cal_invert_mask;
      mask_inversion_pin_out <= cal_mask_pattern_in;
    end
  end

  // Bus inversion is suppressed during calibration
  assign bus_inversion_apply_out = bus_inversion_enable_in && !cal_active_in;

  // Termination decode from the active copy
  wire [2:0] act_code = act_term[`DMR_TERM_CODE_MSB:0];
  assign controller_term_strength_out = act_code;
  assign controller_term_rsvd_out = act_code == `DMR_TERM_CODE_RSVD;
  assign clock_term_en_out = term_value_valid_in && (pad_level || act_term[`DMR_TERM_CK_BIT]);
  assign chip_select_term_en_out = term_value_valid_in && (pad_level || act_term[`DMR_TERM_CS_BIT]);
  assign cmd_addr_term_en_out = term_value_valid_in && pad_level && !act_term[`DMR_TERM_CA_BIT];

  // Checks
  default clocking dmr_cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  chk_low_read: assert property (mrr_valid_in && mr_addr_in == `DMR_ADDR_OSC_LOW
    |=> mrr_valid_out && mrr_data_out == $past(osc_count[7:0])) else $error("low count read wrong");
  chk_high_read: assert property (mrr_valid_in && mr_addr_in == `DMR_ADDR_OSC_HIGH
    |=> mrr_data_out == $past(osc_count[15:8])) else $error("high count read wrong");
  chk_rsvd_read: assert property (mrr_valid_in && mr_addr_in == `DMR_ADDR_RSVD_21
    |=> mrr_data_out == 8'h00) else $error("reserved slot not zero");
  chk_mask_apply: assert property (wr_mask ##1 !wr_mask
    |=> cal_upper_dq_out == ($past(cal_pattern_in) ^ $past(mr_wdata_in, 2))) else $error("mask not applied");
  chk_mask_pin: assert property (1'b1 |=> mask_inversion_pin_out == $past(cal_mask_pattern_in))
    else $error("mask pin inverted");
  chk_no_inversion: assert property (cal_active_in |-> !bus_inversion_apply_out)
    else $error("inversion during calibration");
  chk_ck_override: assert property (term_value_valid_in && act_term[`DMR_TERM_CK_BIT]
    |-> clock_term_en_out) else $error("clock override ignored");
  chk_ca_disable: assert property (act_term[`DMR_TERM_CA_BIT] |-> !cmd_addr_term_en_out)
    else $error("ca termination not disabled");
  chk_setpoint_write: assert property (wr_term ##1 (mrr_valid_in && hit_term
    && write_set_point_select_in == $past(write_set_point_select_in))
    |=> mrr_data_out[5:0] == $past(mr_wdata_in[5:0], 2)) else $error("set point copy mismatch");
  chk_pad_sync: assert property (pad_sync[2] == pad_sync[1] |=> pad_level == $past(pad_sync[2]))
    else $error("pad level not tracked");
endmodule : dmr_mode_regs

// *** logic/dmr_osc_counter.sv ***
// Strobe oscillator counter, cleared and started by the start command
`timescale 1ns/100ps
`include "dmr_cfg.svh"
module dmr_osc_counter #(
  parameter int COUNT_W = 16
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Oscillator control
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic tick_in,
  // Count and state
  output logic [COUNT_W-1:0] count_out,
  output logic running_out
);
  import dmr_pkg::*;

  dmr_osc_state_t state;  // Run state
  dmr_osc_state_t next_state;  // Next run state
  logic [COUNT_W-1:0] next_count;  // Next count
  wire count_full = &count_out;  // Saturation point

  // State decode
  always_comb begin
    next_state = state;
    unique case (state)
      DMR_OSC_IDLE: if (start_in) next_state = DMR_OSC_RUN;
      DMR_OSC_RUN: if (stop_in && !start_in) next_state = DMR_OSC_IDLE;
      // Unused codes of the two-bit state fall back to idle
      default: next_state = DMR_OSC_IDLE;
    endcase
  end

  // Count update, start clears the count
  always_comb begin
    if (start_in) begin
      next_count = '0;
    end else if (state == DMR_OSC_RUN && tick_in && !count_full) begin
      next_count = count_out + {{(COUNT_W-1){1'b0}}, 1'b1};
    end else begin
      next_count = count_out;
    end
  end

  // Registers
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state <= DMR_OSC_IDLE;
      count_out <= '0;
    end else begin
      state <= next_state;
      count_out <= next_count;
    end
  end

  assign running_out = (state == DMR_OSC_RUN);

  chk_start_clears: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    start_in |=> (count_out == '0) && running_out) else $error("count not cleared by start");
  chk_idle_holds: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (!running_out && !start_in) |=> $stable(count_out)) else $error("count moved while idle");
endmodule : dmr_osc_counter

// *** logic/dmr_pkg.sv ***
// Types shared by the mode register slice
package dmr_pkg;
  typedef logic [5:0] dmr_addr_t;  // Mode register address
  typedef logic [7:0] dmr_byte_t;  // Mode register operand
  typedef enum logic [1:0] {DMR_OSC_IDLE, DMR_OSC_RUN} dmr_osc_state_t;  // Oscillator counter state
endpackage : dmr_pkg

// *** test/dmr_ctrl_model.sv ***
// Controller model issuing mode register writes and reads
`timescale 1ns/100ps
module dmr_ctrl_model (
  // Clock
  input wire logic mclk_in,
  // Command side
  output logic mrw_out,
  output logic mrr_out,
  output dmr_pkg::dmr_addr_t addr_out,
  output dmr_pkg::dmr_byte_t wdata_out,
  // Read answer
  input wire dmr_pkg::dmr_byte_t rdata_in,
  input wire logic rvalid_in
);
  import dmr_pkg::*;
  // Idle bus at time zero
  initial begin
    mrw_out = 1'b0;
    mrr_out = 1'b0;
    addr_out = 6'h3F;
    wdata_out = 8'hA5;
  end
  // One write; callers keep the two top termination bits zero
  task automatic wr(input dmr_addr_t a, input dmr_byte_t d);
    @(posedge mclk_in);
    mrw_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    @(posedge mclk_in);
    mrw_out <= 1'b0;
    addr_out <= ~a;  // Released bus shows no stale value
    wdata_out <= ~d;
    #1;
  endtask : wr
  // One read, answer taken in the cycle after the request
  task automatic rd(input dmr_addr_t a, output dmr_byte_t d, output logic v);
    @(posedge mclk_in);
    mrr_out <= 1'b1;
    addr_out <= a;
    @(posedge mclk_in);
    mrr_out <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rdata_in;
    v = rvalid_in;
  endtask : rd
  // Full oscillator count, high byte above low, as used for strobe retuning
  task automatic rd_count(output logic [15:0] c);
    dmr_byte_t l, h;
    logic lv, hv;
    rd(6'h12, l, lv);
    rd(6'h13, h, hv);
    c = {h, l};
  endtask : rd_count
  // Write, then read the same address on the very next edge
  task automatic wr_rd(input dmr_addr_t a, input dmr_byte_t d, output dmr_byte_t q);
    @(posedge mclk_in);
    mrw_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    @(posedge mclk_in);
    mrw_out <= 1'b0;
    mrr_out <= 1'b1;
    @(posedge mclk_in);
    mrr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
    #1;
    q = rdata_in;
  endtask : wr_rd
endmodule : dmr_ctrl_model

// *** test/dmr_mode_regs_test.sv ***
// Self-checking bench for the mode register slice
`timescale 1ns/100ps
module dmr_mode_regs_test;
  import dmr_pkg::*;
  // Bench-driven inputs
  logic mclk_in, rst_n_in, start, stop, tick, wsp, asp, binv_en, tv, pad, cal_act, cal_mp;
  dmr_byte_t cal_pat;
  // Design outputs and model wires
  logic mrw, mode_register_read, rv, v, run, mip, binv_app, rsvd, ck_en, cs_en, ca_en;
  dmr_addr_t addr;
  dmr_byte_t wdata, rdata, cal_dq, lo, hi;
  logic [2:0] strength;
  logic [15:0] cnt;  // Joined oscillator count
  int mismatches, check_count, cycles;
  dmr_mode_regs DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .mrw_valid_in(mrw), .mrr_valid_in(mode_register_read),
    .mr_addr_in(addr), .mr_wdata_in(wdata), .mrr_data_out(rdata), .mrr_valid_out(rv), .osc_start_in(start),
    .osc_stop_in(stop), .osc_tick_in(tick), .osc_running_out(run), .write_set_point_select_in(wsp),
    .active_set_point_select_in(asp), .bus_inversion_enable_in(binv_en), .term_value_valid_in(tv),
    .cmd_bus_term_pad_in(pad), .cal_active_in(cal_act), .cal_pattern_in(cal_pat), .cal_mask_pattern_in(cal_mp),
    .cal_upper_dq_out(cal_dq), .mask_inversion_pin_out(mip), .bus_inversion_apply_out(binv_app),
    .controller_term_strength_out(strength), .controller_term_rsvd_out(rsvd), .clock_term_en_out(ck_en),
    .chip_select_term_en_out(cs_en), .cmd_addr_term_en_out(ca_en));
  dmr_ctrl_model ctrl (.mclk_in(mclk_in), .mrw_out(mrw), .mrr_out(mode_register_read), .addr_out(addr), .wdata_out(wdata),
    .rdata_in(rdata), .rvalid_in(rv));
  // Compare and count
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  // Clock, 8 ns period
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  // Hang guard well above the whole run
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      close_out();
    end
  end
  // Oscillator count across the byte boundary, then cleared by a new start
  task automatic t_osc();
    @(posedge mclk_in);
    start <= 1'b1;
    @(posedge mclk_in);
    start <= 1'b0;
    tick <= 1'b1;
    repeat (300) @(posedge mclk_in);
    tick <= 1'b0;
    stop <= 1'b1;
    @(posedge mclk_in);
    stop <= 1'b0;
    ctrl.rd_count(cnt);
    chk("osc count", cnt, 16'h012C);
    @(posedge mclk_in);
    start <= 1'b1;
    @(posedge mclk_in);
    start <= 1'b0;
    ctrl.wr(6'h12, 8'h55);
    ctrl.rd(6'h12, lo, v);
    ctrl.rd(6'h13, hi, v);
    chk("osc cleared", {hi, lo}, 16'h0000);
    chk("osc running", 16'(run), 16'h0001);
  endtask : t_osc
  // Invert mask on the calibration path, pin passed through, bus inversion suppressed until calibration ends
  task automatic t_cal();
    ctrl.wr(6'h14, 8'h15);
    ctrl.wr(6'h15, 8'hFF);
    ctrl.rd(6'h15, lo, v);
    chk("rsvd read", {7'h00, v, lo}, 16'h0100);
    @(posedge mclk_in);
    {cal_act, cal_mp, binv_en} <= 3'h7;
    cal_pat <= 8'hFF;
    repeat (2) @(posedge mclk_in);
    #1;
    chk("cal dq", 16'(cal_dq), 16'h00EA);
    chk("mask pin", 16'(mip), 16'h0001);
    chk("inv apply", 16'(binv_app), 16'h0000);
    @(posedge mclk_in);
    cal_act <= 1'b0;
    #1;
    chk("inv idle", 16'(binv_app), 16'h0001);
  endtask : t_cal
  // Strength codes, overrides and set point copies
  task automatic t_term();
    chk("reset ovr", 16'({strength, ck_en, cs_en}), 16'h0000);
    for (int c = 0; c < 8; c++) begin
      ctrl.wr(6'h16, 8'(c));
      chk("strength", 16'({rsvd, strength}), 16'(c + (c == 7 ? 8 : 0)));
    end
    ctrl.wr(6'h16, 8'h08);
    chk("ck ovr", 16'({ck_en, cs_en}), 16'h0002);
    ctrl.wr(6'h16, 8'h10);
    chk("cs ovr", 16'({ck_en, cs_en}), 16'h0001);
    @(posedge mclk_in);
    pad <= 1'b1;
    ctrl.wr(6'h16, 8'h00);
    repeat (6) @(posedge mclk_in);
    #1;
    chk("ca pad", 16'(ca_en), 16'h0001);
    ctrl.wr(6'h16, 8'h20);
    chk("ca off", 16'(ca_en), 16'h0000);
    @(posedge mclk_in);
    wsp <= 1'b1;
    ctrl.wr(6'h16, 8'h0E);
    chk("inactive", 16'({strength, ca_en}), 16'h0000);
    ctrl.rd(6'h16, lo, v);
    chk("sp1 read", 16'(lo), 16'h000E);
    @(posedge mclk_in);
    asp <= 1'b1;
    wsp <= 1'b0;
    #1;
    chk("active", 16'({strength, ck_en}), 16'h000D);
    ctrl.rd(6'h16, lo, v);
    chk("sp0 read", 16'(lo), 16'h0020);
    ctrl.wr_rd(6'h16, 8'h21, lo);
    chk("sp0 wr rd", 16'(lo), 16'h0021);
    chk("sp1 kept", 16'({strength, ck_en}), 16'h000D);
    @(posedge mclk_in);
    tv <= 1'b0;
    #1;
    chk("no value", 16'({ck_en, cs_en, ca_en}), 16'h0000);
    @(posedge mclk_in);
    tv <= 1'b1;
  endtask : t_term
  // Main sequence
  initial begin
    {rst_n_in, start, stop, tick, wsp, asp, binv_en, pad, cal_act, cal_mp} = '0;
    tv = 1'b1;
    cal_pat = 8'h00;
    repeat (8) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    #1;
    t_term();
    t_osc();
    t_cal();
    close_out();
  end
endmodule : dmr_mode_regs_test
